//--- hdl/pirq_pkg.sv
// Package with the register map, field layout, reset values and page coding of the interrupt and page block.
package pirq_pkg;

  // Management register addresses.
  localparam logic [4:0] PIRQ_ISR_ADDR      = 5'h12;
  localparam logic [4:0] PIRQ_PAGE_ADDR     = 5'h13;
  localparam logic [4:0] PIRQ_PAGED_LO_ADDR = 5'h14;
  localparam logic [4:0] PIRQ_PAGED_HI_ADDR = 5'h1F;

  // Field positions inside the interrupt status and enable register.
  localparam int PIRQ_EN_LSB       = 0;
  localparam int PIRQ_EN_MSB       = 7;
  localparam int PIRQ_FLAG_BIT     = 8;
  localparam int PIRQ_UPPER_LSB    = 9;
  localparam int PIRQ_UPPER_MSB    = 15;
  localparam int PIRQ_TP_UPPER_IDX = 2;

  // Field positions inside the page choice register.
  localparam int PIRQ_PAGE_LSB = 0;
  localparam int PIRQ_PAGE_MSB = 2;

  // Values after reset.
  localparam logic [7:0]  PIRQ_EN_RESET    = 8'h00;
  localparam logic [2:0]  PIRQ_PAGE_RESET  = 3'h0;
  localparam logic [15:0] PIRQ_RDATA_RESET = 16'h0000;
  localparam logic [12:0] PIRQ_PAGE_RSVD   = 13'h0000;

  // Page field codes.
  localparam logic [2:0] PIRQ_PG_EXTENDED = 3'h0;
  localparam logic [2:0] PIRQ_PG_DIAG     = 3'h2;
  localparam logic [2:0] PIRQ_PG_TP_BASE  = 3'h4;
  localparam logic [2:0] PIRQ_PG_TP_CFG5  = 3'h5;
  localparam logic [2:0] PIRQ_PG_TP_CFG6  = 3'h6;

  // Bank reached by a paged access; none for the reserved codes.
  typedef enum logic [4:0] {
    PIRQ_BANK_NONE     = 5'b00001,
    PIRQ_BANK_EXTENDED = 5'b00010,
    PIRQ_BANK_DIAG     = 5'b00100,
    PIRQ_BANK_TP_BASE  = 5'b01000,
    PIRQ_BANK_TP_CFG   = 5'b10000
  } pirq_bank_type;

  // Maps the page field onto the bank it opens.
  function automatic pirq_bank_type pirq_page_to_bank(input logic [2:0] page);
    unique case (page)
      PIRQ_PG_EXTENDED: pirq_page_to_bank = PIRQ_BANK_EXTENDED;
      PIRQ_PG_DIAG:     pirq_page_to_bank = PIRQ_BANK_DIAG;
      PIRQ_PG_TP_BASE:  pirq_page_to_bank = PIRQ_BANK_TP_BASE;
      PIRQ_PG_TP_CFG5,
      PIRQ_PG_TP_CFG6:  pirq_page_to_bank = PIRQ_BANK_TP_CFG;
      default:          pirq_page_to_bank = PIRQ_BANK_NONE;
    endcase
  endfunction : pirq_page_to_bank

endpackage : pirq_pkg

//--- hdl/pirq_page_if.sv
// Interface that carries a management address and page field to the page decoder and its verdict back.
`timescale 1ns/1ps
interface pirq_page_if;
  logic [4:0]             addr;
  logic [2:0]             page;
  logic                   paged;
  pirq_pkg::pirq_bank_type bank;

  modport ctrl (output addr, output page, input paged, input bank);
  modport dec  (input addr, input page, output paged, output bank);
endinterface : pirq_page_if

//--- hdl/pirq_page_decode.sv
// Combinational decoder that tells whether an address is paged and which bank the page opens.
`timescale 1ns/1ps
module pirq_page_decode (
  pirq_page_if.dec pg
);

  // Only the upper window is paged; everything below it decodes the same on every page.
  always_comb begin
    pg.paged = (pg.addr >= pirq_pkg::PIRQ_PAGED_LO_ADDR) && (pg.addr <= pirq_pkg::PIRQ_PAGED_HI_ADDR);
    pg.bank  = pg.paged ? pirq_pkg::pirq_page_to_bank(pg.page) : pirq_pkg::PIRQ_BANK_NONE;
  end

endmodule : pirq_page_decode

//--- hdl/pirq_cor_flag.sv
// Sticky pending flag that clears on a read, where a new event beats the clear.
`timescale 1ns/1ps
module pirq_cor_flag (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic ce,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag
);

  typedef struct packed {
    logic flag;
  } pirq_flag_state_type;

  pirq_flag_state_type st_q;
  pirq_flag_state_type st_d;

  // Set wins over clear so an event landing on the reading cycle stays pending.
  always_comb begin
    st_d = st_q;
    if (ce) begin
      st_d.flag = set | (st_q.flag & ~clr);
    end
  end

  // State register.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign flag = st_q.flag;

endmodule : pirq_cor_flag

//--- hdl/pirq_top.sv
// Interrupt status and enable register plus page choice register of the management block.
//
// Operation
// - With both PHY-control selectors zero, bit 8 flags receive-error half-full, cleared on read.
// - With either selector set, bit 8 flags a control frame, cleared on read.
// - Bit 7 is a read-write link quality interrupt enable, zero after reset.
// - Bit 6 is a read-write energy detect interrupt enable, zero after reset.
// - Bit 5 is a read-write link status change interrupt enable, zero after reset.
// - Bit 4 is a read-write speed change interrupt enable, zero after reset.
// - Bit 3 enables duplex change, or time protocol when control mode bit is one.
// - Bit 2 is a read-write autonegotiation done interrupt enable, zero after reset.
// - With selectors zero, bit 1 enables the false carrier half-full interrupt.
// - With frame config bits set, bit 1 enables either counter half-full interrupt.
// - With selectors zero, bit 0 enables the receive error half-full interrupt.
// - With either PHY-control selector set, bit 0 enables the control frame interrupt.
// - Page register bits 15 to 3 ignore writes and read as zero.
// - The page field picks the bank at addresses 14h to 1Fh only.
// - Page 2 diagnostics, 4 time base, 5 and 6 time config, 1, 3 and 7 reserved.
// - The page field resets to zero, the extended page, and is read-write.
// - In time protocol mode a pending interrupt rearms only once its status is empty.
`timescale 1ns/1ps
module pirq_top (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic [4:0]  mgmt_addr,
  input  wire logic        mgmt_rd,
  input  wire logic        mgmt_wr,
  input  wire logic [15:0] mgmt_wdata,
  input  wire logic [1:0]  second_phy_control_sel,
  input  wire logic        interrupt_control_mode,
  input  wire logic [1:0]  control_frame_config_sel,
  input  wire logic        rx_err_half_evt,
  input  wire logic        control_frame_evt,
  input  wire logic        time_protocol_evt,
  input  wire logic        time_protocol_status_avail,
  input  wire logic [6:0]  upper_pending,
  output logic [15:0]      mgmt_rdata,
  output logic             mgmt_rvalid,
  output logic             irq,
  output logic             time_protocol_pending,
  output logic [2:0]       page,
  output logic             paged_access,
  output logic [4:0]       paged_bank
);

  typedef struct packed {
    logic [7:0]              en;
    logic [2:0]              page;
    logic [15:0]             rdata;
    logic                    rvalid;
    logic                    irq;
    logic                    tp_armed;
    logic                    tp_pend;
    logic                    paged_acc;
    pirq_pkg::pirq_bank_type bank;
  } pirq_state_type;

  pirq_state_type st_q;
  pirq_state_type st_d;

  logic        isr_rd;
  logic        isr_wr;
  logic        page_rd;
  logic        page_wr;
  logic        cf_mode;
  logic        flag_set;
  logic        rx_err_half_pending;
  logic [15:0] isr_view;
  logic [7:0]  pend_vec;

  pirq_page_if pg ();

  // Access decode for the two registers held here.
  assign isr_rd  = mgmt_rd && (mgmt_addr == pirq_pkg::PIRQ_ISR_ADDR);
  assign isr_wr  = mgmt_wr && (mgmt_addr == pirq_pkg::PIRQ_ISR_ADDR);
  assign page_rd = mgmt_rd && (mgmt_addr == pirq_pkg::PIRQ_PAGE_ADDR);
  assign page_wr = mgmt_wr && (mgmt_addr == pirq_pkg::PIRQ_PAGE_ADDR);

  // The shared pending bit follows the control frame source as soon as either selector is set.
  assign cf_mode  = |second_phy_control_sel;
  assign flag_set = cf_mode ? control_frame_evt : rx_err_half_evt;

  // Pending bit 8 lives in its own sticky flag; the status read is its clear.
  pirq_cor_flag u_flag (
    .core_clk (core_clk),
    .reset    (reset),
    .ce       (ce),
    .set      (flag_set),
    .clr      (isr_rd),
    .flag     (rx_err_half_pending)
  );

  // Page decoder sees the live address and the current page.
  assign pg.addr = mgmt_addr;
  assign pg.page = st_q.page;

  pirq_page_decode u_dec (
    .pg (pg)
  );

  // Status view: upper bits come from the other sources, except that the time protocol slot is ours in that mode.
  always_comb begin
    isr_view = {upper_pending, rx_err_half_pending, st_q.en};
    if (interrupt_control_mode) begin
      isr_view[pirq_pkg::PIRQ_UPPER_LSB + pirq_pkg::PIRQ_TP_UPPER_IDX] = st_q.tp_pend;
    end
  end

  // Each enable bit i gates pending bit 8 + i; the meaning of a shared slot is set by the selectors outside.
  assign pend_vec = isr_view[pirq_pkg::PIRQ_UPPER_MSB:pirq_pkg::PIRQ_FLAG_BIT];

  // Next state of the register file and the time protocol arming.
  always_comb begin
    st_d = st_q;
    if (ce) begin
      st_d.rvalid    = mgmt_rd;
      st_d.paged_acc = (mgmt_rd || mgmt_wr) && pg.paged;
      if (mgmt_rd || mgmt_wr) begin
        st_d.bank = pg.bank;
      end
      // Unmapped or paged addresses read zero here; the banks answer on their own path.
      st_d.rdata = pirq_pkg::PIRQ_RDATA_RESET;
      if (isr_rd) begin
        st_d.rdata = isr_view;
      end else if (page_rd) begin
        st_d.rdata = {pirq_pkg::PIRQ_PAGE_RSVD, st_q.page};
      end
      if (isr_wr) begin
        st_d.en = mgmt_wdata[pirq_pkg::PIRQ_EN_MSB:pirq_pkg::PIRQ_EN_LSB];
      end
      if (page_wr) begin
        st_d.page = mgmt_wdata[pirq_pkg::PIRQ_PAGE_MSB:pirq_pkg::PIRQ_PAGE_LSB];
      end
      // One time protocol interrupt per burst of status; it rearms once the status is drained and read.
      if (interrupt_control_mode && time_protocol_evt && st_q.tp_armed) begin
        st_d.tp_pend  = 1'b1;
        st_d.tp_armed = 1'b0;
      end else begin
        if (isr_rd && interrupt_control_mode) begin
          st_d.tp_pend = 1'b0;
        end
        if (!st_q.tp_pend && !time_protocol_status_avail) begin
          st_d.tp_armed = 1'b1;
        end
      end
      st_d.irq = |(pend_vec & st_q.en);
    end
  end

  // State register; reset leaves all enables off and the extended page chosen.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q.en        <= pirq_pkg::PIRQ_EN_RESET;
      st_q.page      <= pirq_pkg::PIRQ_PAGE_RESET;
      st_q.rdata     <= pirq_pkg::PIRQ_RDATA_RESET;
      st_q.rvalid    <= 1'b0;
      st_q.irq       <= 1'b0;
      st_q.tp_armed  <= 1'b1;
      st_q.tp_pend   <= 1'b0;
      st_q.paged_acc <= 1'b0;
      st_q.bank      <= pirq_pkg::PIRQ_BANK_NONE;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register.
  assign mgmt_rdata            = st_q.rdata;
  assign mgmt_rvalid           = st_q.rvalid;
  assign irq                   = st_q.irq;
  assign time_protocol_pending = st_q.tp_pend;
  assign page                  = st_q.page;
  assign paged_access          = st_q.paged_acc;
  assign paged_bank            = st_q.bank;

  // Checks on the behaviour above.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_flag_rx_source: assert property (
    (ce && !cf_mode && rx_err_half_evt) |=> rx_err_half_pending)
    else $error("receive error half-full event did not set bit 8");

  a_flag_cf_source: assert property (
    (ce && cf_mode && control_frame_evt) |=> rx_err_half_pending)
    else $error("control frame event did not set bit 8");

  a_flag_read_clear: assert property (
    (ce && isr_rd && !flag_set) |=> !rx_err_half_pending ##0 mgmt_rdata[pirq_pkg::PIRQ_FLAG_BIT] == $past(rx_err_half_pending))
    else $error("status read did not return and clear bit 8");

  a_set_beats_clear: assert property (
    (ce && isr_rd && flag_set) |=> rx_err_half_pending)
    else $error("event during status read was lost");

  a_enable_store: assert property (
    (ce && isr_wr) |=> (st_q.en == $past(mgmt_wdata[7:0])))
    else $error("enable bits did not take the written value");

  a_page_rsvd_zero: assert property (
    (ce && page_rd) |=> mgmt_rvalid && (mgmt_rdata[15:3] == 13'h0000) && (mgmt_rdata[2:0] == $past(st_q.page)))
    else $error("page register read back wrong");

  a_reset_values: assert property (disable iff (1'b0)
    reset |=> (page == 3'h0) && (st_q.en == 8'h00) && !irq)
    else $error("page or enables not cleared by reset");

  a_paged_bank: assert property (
    (ce && mgmt_rd && mgmt_addr >= 5'h14) |=> paged_access && (paged_bank == $past(pirq_pkg::pirq_page_to_bank(st_q.page))))
    else $error("paged access did not report the chosen bank");

  a_unpaged_low: assert property (
    (ce && mgmt_rd && mgmt_addr < 5'h14) |=> !paged_access)
    else $error("low address was treated as paged");

  a_irq_merge: assert property (
    (ce && rx_err_half_pending && st_q.en[0]) |=> irq)
    else $error("enabled pending flag did not raise the interrupt");

  a_tp_no_rearm: assert property (
    (ce && !st_q.tp_armed && !st_q.tp_pend) |=> !time_protocol_pending)
    else $error("time protocol interrupt set while disarmed");

  // Holding, freezing, the time protocol slot and the read path; these catch a stray write or a lost pulse.
  a_flag_hold: assert property (
    (ce && !isr_rd && rx_err_half_pending) |=> rx_err_half_pending)
    else $error("bit 8 dropped without a status read");

  a_rx_ignored_cf: assert property (
    (ce && cf_mode && !control_frame_evt && !rx_err_half_pending) |=> !rx_err_half_pending)
    else $error("bit 8 set by a source that is not selected");

  a_cf_ignored_rx: assert property (
    (ce && !cf_mode && !rx_err_half_evt && !rx_err_half_pending) |=> !rx_err_half_pending)
    else $error("bit 8 set while the receive error source was quiet");

  a_enable_hold: assert property (
    (ce && !isr_wr) |=> $stable(st_q.en))
    else $error("enable bits changed without a write");

  a_page_store: assert property (
    (ce && page_wr) |=> (page == $past(mgmt_wdata[pirq_pkg::PIRQ_PAGE_MSB:pirq_pkg::PIRQ_PAGE_LSB])))
    else $error("page field did not take the written value");

  a_page_hold: assert property (
    (ce && !page_wr) |=> $stable(page))
    else $error("page field changed without a write");

  a_ce_freeze: assert property (
    (!ce) |=> ($stable(st_q) && $stable(rx_err_half_pending)))
    else $error("state moved while the clock enable was low");

  a_rvalid_pulse: assert property (
    (ce && !mgmt_rd) |=> !mgmt_rvalid)
    else $error("read valid without a read");

  a_irq_quiet: assert property (
    (ce && ((pend_vec & st_q.en) == 8'h00)) |=> !irq)
    else $error("interrupt raised with no enabled pending flag");

  a_tp_set: assert property (
    (ce && interrupt_control_mode && time_protocol_evt && st_q.tp_armed) |=> (time_protocol_pending && !st_q.tp_armed))
    else $error("armed time protocol event did not pend and disarm");

  a_tp_read_clear: assert property (
    (ce && interrupt_control_mode && isr_rd && !(time_protocol_evt && st_q.tp_armed)) |=> !time_protocol_pending)
    else $error("status read did not clear the time protocol flag");

  a_tp_view: assert property (
    (ce && isr_rd && interrupt_control_mode) |=> (mgmt_rdata[pirq_pkg::PIRQ_UPPER_LSB + pirq_pkg::PIRQ_TP_UPPER_IDX] ==
    $past(st_q.tp_pend)))
    else $error("time protocol slot read back wrong");

  a_tp_wait_status: assert property (
    (ce && time_protocol_status_avail && !st_q.tp_armed) |=> !st_q.tp_armed)
    else $error("time protocol rearmed while status was waiting");

  a_upper_passthru: assert property (
    (ce && isr_rd && !interrupt_control_mode) |=> (mgmt_rdata[pirq_pkg::PIRQ_UPPER_MSB:pirq_pkg::PIRQ_UPPER_LSB] ==
    $past(upper_pending)))
    else $error("upper pending bits read back wrong");

  a_other_addr_zero: assert property (
    (ce && mgmt_rd && !isr_rd && !page_rd) |=> (mgmt_rdata == 16'h0000))
    else $error("foreign address did not read zero");

  a_paged_top: assert property (
    (ce && mgmt_rd && (mgmt_addr == pirq_pkg::PIRQ_PAGED_HI_ADDR)) |=> paged_access)
    else $error("top of the paged window was not paged");

  a_enable_readback: assert property (
    (ce && isr_rd) |=> (mgmt_rdata[pirq_pkg::PIRQ_EN_MSB:pirq_pkg::PIRQ_EN_LSB] == $past(st_q.en)))
    else $error("enable bits read back wrong");

  // Scenarios worth seeing in a run.
  c_flag_cleared: cover property (rx_err_half_pending && ce && isr_rd && !flag_set ##1 !rx_err_half_pending);
  c_set_on_read:  cover property (ce && isr_rd && flag_set);
  c_tp_pending:   cover property (time_protocol_pending ##1 !time_protocol_pending);
  c_page_tp_base: cover property (ce && page_wr && mgmt_wdata[2:0] == 3'h4);
  c_cfg_either:   cover property (ce && (|control_frame_config_sel) && rx_err_half_pending && st_q.en[0]);

endmodule : pirq_top

//--- tb/test_phy_irq_enable_and_page_select.sv
// Self-checking testbench for the interrupt status, enable and page choice registers.
`timescale 1ns/1ps
module test_phy_irq_enable_and_page_select;
  logic        core_clk  = 1'b0;
  logic        reset     = 1'b1;
  logic        ce        = 1'b1;
  logic        mgmt_rd   = 1'b0;
  logic        mgmt_wr   = 1'b0;
  logic        mode      = 1'b0;
  logic        avail     = 1'b0;
  logic [4:0]  mgmt_addr = 5'h00;
  logic [15:0] mgmt_wdata = 16'h0000;
  logic [1:0]  sel       = 2'h0;
  logic [2:0]  evts      = 3'h0;
  logic [6:0]  up        = 7'h00;
  logic [15:0] mgmt_rdata;
  logic        mgmt_rvalid;
  logic        irq;
  logic        time_protocol_pending;
  logic [2:0]  page;
  logic        paged_access;
  logic [4:0]  paged_bank;
  logic [15:0] rd_data;
  logic        rd_pa;
  logic        rd_ok;
  logic [4:0]  rd_bank;
  int          miscompares = 0;
  int          n_tests     = 0;
  // Expected one-hot bank for each page code; reserved codes open nothing.
  logic [4:0]  bank_tab [8] = '{5'h02, 5'h01, 5'h04, 5'h01, 5'h08, 5'h10, 5'h10, 5'h01};

  pirq_top dut_u (
    .core_clk(core_clk), .reset(reset), .ce(ce), .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd),
    .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata), .second_phy_control_sel(sel),
    .interrupt_control_mode(mode), .control_frame_config_sel(sel), .rx_err_half_evt(evts[0]),
    .control_frame_evt(evts[1]), .time_protocol_evt(evts[2]), .time_protocol_status_avail(avail),
    .upper_pending(up), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .irq(irq),
    .time_protocol_pending(time_protocol_pending), .page(page), .paged_access(paged_access),
    .paged_bank(paged_bank)
  );

  // Free-running 100 MHz clock.
  always #5 core_clk = ~core_clk;

  // Inputs always move 1 ns after the rising edge so they never race the sampling edge.
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    tick;
    mgmt_addr  = a;
    mgmt_wdata = d;
    mgmt_wr    = 1'b1;
    tick;
    mgmt_wr = 1'b0;
  endtask : wr

  // The answer is registered, so it is captured one edge after the strobe.
  task automatic rd(input logic [4:0] a, input logic [2:0] ev);
    tick;
    mgmt_addr = a;
    mgmt_rd   = 1'b1;
    evts      = ev;
    tick;
    mgmt_rd = 1'b0;
    evts    = 3'h0;
    rd_data = mgmt_rdata;
    rd_pa   = paged_access;
    rd_bank = paged_bank;
    rd_ok   = mgmt_rvalid;
  endtask : rd

  task automatic pulse(input logic [2:0] ev);
    tick;
    evts = ev;
    tick;
    evts = 3'h0;
  endtask : pulse

  // Narrow results are zero-extended, so a stray unknown still fails.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict;
    if (miscompares == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  // Watchdog; the whole sequence needs well under this many cycles.
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    give_verdict;
  end

  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    reset = 1'b0;
    rd(5'h12, 3'h0);
    chk(rd_data, 16'h0000);
    chk({15'h0, rd_ok}, 16'h0001);
    rd(5'h13, 3'h0);
    chk(rd_data, 16'h0000);
    wr(5'h12, 16'hFFFF);
    rd(5'h12, 3'h0);
    chk(rd_data, 16'h00FF);
    wr(5'h12, 16'h0000);
    rd(5'h12, 3'h0);
    chk(rd_data, 16'h0000);
    wr(5'h13, 16'hFFFF);
    rd(5'h13, 3'h0);
    chk(rd_data, 16'h0007);
    // A write while the clock enable is low must leave the page alone.
    tick;
    ce = 1'b0;
    mgmt_addr = 5'h13;
    mgmt_wdata = 16'h0002;
    mgmt_wr = 1'b1;
    tick;
    mgmt_wr = 1'b0;
    ce = 1'b1;
    chk({13'h0, page}, 16'h0007);
    for (int p = 0; p < 8; p++) begin
      wr(5'h13, 16'(p));
      rd(5'h14, 3'h0);
      chk({15'h0, rd_pa}, 16'h0001);
      chk({11'h0, rd_bank}, {11'h0, bank_tab[p]});
      rd(5'h13, 3'h0);
      chk(rd_data, 16'(p));
    end
    rd(5'h1F, 3'h0);
    chk({15'h0, rd_pa}, 16'h0001);
    rd(5'h11, 3'h0);
    chk({15'h0, rd_pa}, 16'h0000);
    wr(5'h13, 16'h0000);
    // Bit 8 source follows the selector bits.
    pulse(3'h1);
    rd(5'h12, 3'h0);
    chk(rd_data, 16'h0100);
    rd(5'h12, 3'h0);
    chk(rd_data, 16'h0000);
    sel = 2'h1;
    pulse(3'h1);
    rd(5'h12, 3'h0);
    chk(rd_data, 16'h0000);
    pulse(3'h2);
    rd(5'h12, 3'h0);
    chk(rd_data, 16'h0100);
    rd(5'h12, 3'h0);
    chk(rd_data, 16'h0000);
    sel = 2'h0;
    // An event landing with the read must survive to the next read.
    rd(5'h12, 3'h1);
    chk(rd_data, 16'h0000);
    rd(5'h12, 3'h0);
    chk(rd_data, 16'h0100);
    pulse(3'h1);
    repeat (3) tick;
    chk({15'h0, irq}, 16'h0000);
    wr(5'h12, 16'h0001);
    repeat (2) tick;
    chk({15'h0, irq}, 16'h0001);
    rd(5'h12, 3'h0);
    repeat (3) tick;
    chk({15'h0, irq}, 16'h0000);
    up = 7'h40;
    wr(5'h12, 16'h0080);
    repeat (3) tick;
    chk({15'h0, irq}, 16'h0001);
    rd(5'h12, 3'h0);
    chk(rd_data, 16'h8080);
    up = 7'h00;
    // Time protocol mode: no rearm while status is still waiting.
    mode  = 1'b1;
    avail = 1'b1;
    wr(5'h12, 16'h0008);
    pulse(3'h4);
    tick;
    chk({15'h0, time_protocol_pending}, 16'h0001);
    repeat (2) tick;
    chk({15'h0, irq}, 16'h0001);
    rd(5'h12, 3'h0);
    chk(rd_data, 16'h0808);
    rd(5'h12, 3'h0);
    chk(rd_data, 16'h0008);
    pulse(3'h4);
    tick;
    chk({15'h0, time_protocol_pending}, 16'h0000);
    avail = 1'b0;
    repeat (2) tick;
    pulse(3'h4);
    tick;
    chk({15'h0, time_protocol_pending}, 16'h0001);
    give_verdict;
  end
endmodule : test_phy_irq_enable_and_page_select
